// *** common/frame_decoder_consts.vh ***
// Constants for the serial program frame decoder.
// Assumes 16-bit frames, most significant bit first, one frame per chip select.
`ifndef FRAME_DECODER_CONSTS_VH
`define FRAME_DECODER_CONSTS_VH

// Frame layout
`define FRAME_BITS          16
`define CMD_MSB             15
`define CMD_LSB             12
`define SCAN_DEPTH_MSB      9
`define SCAN_DEPTH_LSB      6
`define THR_MSB             9
`define THR_LSB             0
`define CH_LOW_MSB          15
`define CH_LOW_LSB          14
`define HIGH_LOW_SEL_BIT    13
`define EXIT_PROGRAM_BIT    12
`define GROUP_MSB           13
`define GROUP_LSB           12

// Command codes in the command field
`define CMD_CONTINUE        4'h0
`define CMD_SCAN_DEPTH      4'h9
`define CMD_ALARM_PREFIX    2'h3

// Sequencing modes, driven by mode control logic outside this block
`define MODE_MANUAL         2'h0
`define MODE_AUTO_FULL      2'h1
`define MODE_AUTO_LIMITED   2'h2

// Reset values
`define LAST_CH_RESET       4'h7
`define CHANNEL_ZERO        4'h0
`define THR_HIGH_RESET      10'h3ff
`define THR_LOW_RESET       10'h000

`endif

// *** rtl/pin_sync.v ***
// Two-flop synchroniser for one pin, with edge pulses on the clean copy.
// Assumes the pin is asynchronous to clk and slower than half of it.
`timescale 1ns/1ns

module pin_sync #(
    parameter RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire clk,
    input  wire rstn,
    // Pin side
    input  wire pin,
    // Synchronised side
    output reg  level_r,
    output wire rise,
    output wire fall
);

    reg meta_r;
    reg prev_r;

    // First flop feeds only the second one
    always @(posedge clk) begin
        if (!rstn) begin
            meta_r  <= RESET_LEVEL;
            level_r <= RESET_LEVEL;
            prev_r  <= RESET_LEVEL;
        end else begin
            meta_r  <= pin;
            level_r <= meta_r;
            prev_r  <= level_r;
        end
    end

    // Edges seen only on the settled copy
    assign rise = level_r & ~prev_r;
    assign fall = ~level_r & prev_r;

endmodule

// *** rtl/adc_serial_program_frame_decoder.v ***
// Serial program frame decoder: scan depth, continue and alarm threshold frames.
// Assumes the serial pins are asynchronous and sclk is far slower than clk;
// conversion results and the mode come from logic on clk.
`timescale 1ns/1ns
`include "frame_decoder_consts.vh"

module adc_serial_program_frame_decoder #(
    parameter NUM_CH = 8
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Serial pins from the host
    input  wire       cs_n,
    input  wire       sclk,
    input  wire       sdi,
    // Serial data back to the host
    output reg        sdo_r,
    output reg        sdo_oe_r,
    // Mode and manual channel from mode control
    input  wire [1:0] mode,
    input  wire [3:0] manual_channel,
    // Conversion results
    input  wire       conv_valid,
    input  wire [3:0] conv_channel,
    input  wire [9:0] conv_result,
    // Sequencer and status
    output reg  [3:0] channel_r,
    output reg  [3:0] limited_scan_last_channel_r,
    output reg        program_lock_r,
    output reg        frame_done_r,
    output reg        continue_seen_r,
    // Alarm flags, one per channel
    output reg  [NUM_CH-1:0] alarm_high_r,
    output reg  [NUM_CH-1:0] alarm_low_r
);

    // One-hot decoder states
    localparam [1:0] ST_NORMAL = 2'b01;
    localparam [1:0] ST_ALARM  = 2'b10;

    wire       cs_s;
    wire       cs_fall;
    wire       sclk_rise;
    wire       sclk_fall;
    wire       sdi_s;

    reg  [15:0] rx_r;
    reg  [4:0]  bit_cnt_r;
    reg         decode_r;
    reg  [15:0] tx_r;
    reg  [9:0]  last_result_r;
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [1:0]  group_r;
    reg  [3:0]  channel_nxt;
    reg  [9:0]  thr_high_r [0:NUM_CH-1];
    reg  [9:0]  thr_low_r  [0:NUM_CH-1];

    wire [3:0]  cmd      = rx_r[`CMD_MSB:`CMD_LSB];
    wire [3:0]  tgt_ch   = {group_r, rx_r[`CH_LOW_MSB:`CH_LOW_LSB]};
    wire        tgt_ok   = ({28'h0, tgt_ch} < NUM_CH);
    wire        conv_ok  = ({28'h0, conv_channel} < NUM_CH);
    wire        last_bit = (bit_cnt_r == 5'h0f);

    integer i;

    // Pin synchronisers; only the settled copies are read below
    pin_sync #(.RESET_LEVEL(1'b1)) u_cs (
        .clk     (clk),
        .rstn    (rstn),
        .pin     (cs_n),
        .level_r (cs_s),
        .rise    (),
        .fall    (cs_fall)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) u_sclk (
        .clk     (clk),
        .rstn    (rstn),
        .pin     (sclk),
        .level_r (),
        .rise    (sclk_rise),
        .fall    (sclk_fall)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) u_sdi (
        .clk     (clk),
        .rstn    (rstn),
        .pin     (sdi),
        .level_r (sdi_s),
        .rise    (),
        .fall    ()
    );

    // frame capture, MSB first
    // Bits past the sixteenth are dropped so a long frame decodes once.
    always @(posedge clk) begin
        if (!rstn) begin
            rx_r      <= 16'h0000;
            bit_cnt_r <= 5'h00;
            decode_r  <= 1'b0;
        end else begin
            decode_r <= 1'b0;
            if (cs_fall) begin
                bit_cnt_r <= 5'h00;
            end else if (!cs_s && sclk_rise && bit_cnt_r < `FRAME_BITS) begin
                rx_r      <= {rx_r[14:0], sdi_s};
                bit_cnt_r <= bit_cnt_r + 5'h01;
                decode_r  <= last_bit;
            end
        end
    end

    // Serial out: channel address then latest result, shifted on sclk falls
    // Result is taken at the frame start so it cannot change mid-frame.
    always @(posedge clk) begin
        if (!rstn) begin
            tx_r     <= 16'h0000;
            sdo_r    <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else begin
            sdo_oe_r <= ~cs_s;
            if (cs_fall) begin
                tx_r  <= {channel_r, last_result_r, 2'b00};
                sdo_r <= channel_r[3];
            end else if (!cs_s && sclk_fall) begin
                tx_r  <= {tx_r[14:0], 1'b0};
                sdo_r <= tx_r[14];
            end
        end
    end

    // Next state of the decoder
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL: begin
                if (decode_r && cmd[3:2] == `CMD_ALARM_PREFIX) begin
                    state_nxt = ST_ALARM;
                end
            end
            ST_ALARM: begin
                if (decode_r && rx_r[`EXIT_PROGRAM_BIT]) begin
                    state_nxt = ST_NORMAL;
                end
            end
            default: begin
                state_nxt = ST_NORMAL;
            end
        endcase
    end

    // State, group and lock flag
    always @(posedge clk) begin
        if (!rstn) begin
            state_r        <= ST_NORMAL;
            group_r        <= 2'h0;
            program_lock_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_NORMAL && state_nxt == ST_ALARM) begin
                group_r <= cmd[1:0];
            end
            program_lock_r <= (state_nxt == ST_ALARM);
        end
    end

    // Scan depth register
    always @(posedge clk) begin
        if (!rstn) begin
            limited_scan_last_channel_r <= `LAST_CH_RESET;
        end else if (decode_r && state_r == ST_NORMAL && cmd == `CMD_SCAN_DEPTH) begin
            limited_scan_last_channel_r <= rx_r[`SCAN_DEPTH_MSB:`SCAN_DEPTH_LSB];
        end
    end

    // Channel sequencer, steps once per decoded frame
    always @* begin
        channel_nxt = channel_r;
        case (mode)
            `MODE_AUTO_LIMITED: begin
                if (channel_r == limited_scan_last_channel_r) begin
                    channel_nxt = `CHANNEL_ZERO;
                end else begin
                    channel_nxt = channel_r + 4'h1;
                end
            end
            `MODE_AUTO_FULL: begin
                if ({28'h0, channel_r} >= NUM_CH - 1) begin
                    channel_nxt = `CHANNEL_ZERO;
                end else begin
                    channel_nxt = channel_r + 4'h1;
                end
            end
            default: begin
                channel_nxt = manual_channel;
            end
        endcase
    end

    // Channel register and per-frame pulses
    // Sequencing keeps running during programming so conversions go on.
    always @(posedge clk) begin
        if (!rstn) begin
            channel_r       <= `CHANNEL_ZERO;
            frame_done_r    <= 1'b0;
            continue_seen_r <= 1'b0;
        end else begin
            frame_done_r    <= decode_r;
            continue_seen_r <= decode_r && state_r == ST_NORMAL && cmd == `CMD_CONTINUE;
            if (decode_r) begin
                channel_r <= channel_nxt;
            end
        end
    end

    // Threshold storage and writes
    always @(posedge clk) begin
        if (!rstn) begin
            for (i = 0; i < NUM_CH; i = i + 1) begin
                thr_high_r[i] <= `THR_HIGH_RESET;
                thr_low_r[i]  <= `THR_LOW_RESET;
            end
        end else if (decode_r && state_r == ST_ALARM && tgt_ok) begin
            if (rx_r[`HIGH_LOW_SEL_BIT]) begin
                thr_high_r[tgt_ch[2:0]] <= rx_r[`THR_MSB:`THR_LSB];
            end else begin
                thr_low_r[tgt_ch[2:0]]  <= rx_r[`THR_MSB:`THR_LSB];
            end
        end
    end

    // Alarm compare on each result of a channel below NUM_CH; flags follow the latest conversion
    always @(posedge clk) begin
        if (!rstn) begin
            last_result_r <= 10'h000;
            alarm_high_r  <= {NUM_CH{1'b0}};
            alarm_low_r   <= {NUM_CH{1'b0}};
        end else if (conv_valid) begin
            last_result_r <= conv_result;
            if (conv_ok) begin
                alarm_high_r[conv_channel[2:0]] <= conv_result > thr_high_r[conv_channel[2:0]];
                alarm_low_r[conv_channel[2:0]]  <= conv_result < thr_low_r[conv_channel[2:0]];
            end
        end
    end

endmodule

// *** tb/frame_decoder_properties.sv ***
// Checker for the serial program frame decoder, bound to its ports.
// Assumes a single clk domain with synchronous active-low rstn.
`timescale 1ns/1ns
`include "frame_decoder_consts.vh"
module frame_decoder_properties #(
    parameter NUM_CH = 8
) (
    // Clock and reset
    input wire              clk,
    input wire              rstn,
    // Pins, mode and conversion inputs
    input wire              cs_n,
    input wire [1:0]        mode,
    input wire [3:0]        manual_channel,
    input wire              conv_valid,
    input wire [3:0]        conv_channel,
    input wire [9:0]        conv_result,
    // Design outputs
    input wire              sdo_oe_r,
    input wire [3:0]        channel_r,
    input wire [3:0]        limited_scan_last_channel_r,
    input wire              program_lock_r,
    input wire              frame_done_r,
    input wire              continue_seen_r,
    input wire [NUM_CH-1:0] alarm_high_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_done_pulse; frame_done_r |=> !frame_done_r; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_cont_done; continue_seen_r |-> frame_done_r; endproperty
    a_cont_done: assert property (p_cont_done) else $error("continue off frame");
    property p_last_hold; !frame_done_r |-> $stable(limited_scan_last_channel_r); endproperty
    a_last_hold: assert property (p_last_hold) else $error("last channel moved");
    property p_lock_hold; !frame_done_r |-> $stable(program_lock_r); endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock moved");
    // Limited scan only judged when mode and depth are settled
    property p_step;
        frame_done_r && mode == `MODE_AUTO_LIMITED && $stable(mode)
        && $stable(limited_scan_last_channel_r)
        && $past(channel_r) != limited_scan_last_channel_r
        |-> channel_r == $past(channel_r) + 4'h1;
    endproperty
    a_step: assert property (p_step) else $error("channel did not step");
    property p_wrap;
        frame_done_r && mode == `MODE_AUTO_LIMITED && $stable(mode)
        && $stable(limited_scan_last_channel_r)
        && $past(channel_r) == limited_scan_last_channel_r |-> channel_r == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("channel did not wrap");
    property p_manual;
        frame_done_r && mode == `MODE_MANUAL && $stable(manual_channel)
        |-> channel_r == manual_channel;
    endproperty
    a_manual: assert property (p_manual) else $error("manual channel lost");
    property p_oe_on; $fell(cs_n) |-> ##[2:4] sdo_oe_r; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output not enabled");
    property p_zero_no_high;
        conv_valid && conv_result == 10'h000 |=> !alarm_high_r[$past(conv_channel[2:0])];
    endproperty
    a_zero_no_high: assert property (p_zero_no_high) else $error("bad high alarm");

    // Main scenarios reached
    c_cont: cover property (continue_seen_r);
    c_prog: cover property (program_lock_r && frame_done_r);
    c_wrap: cover property (frame_done_r && channel_r == 4'h0 && mode == `MODE_AUTO_LIMITED);
endmodule

bind adc_serial_program_frame_decoder frame_decoder_properties #(.NUM_CH(NUM_CH)) u_props (
    .clk                         (clk),
    .rstn                        (rstn),
    .cs_n                        (cs_n),
    .mode                        (mode),
    .manual_channel              (manual_channel),
    .conv_valid                  (conv_valid),
    .conv_channel                (conv_channel),
    .conv_result                 (conv_result),
    .sdo_oe_r                    (sdo_oe_r),
    .channel_r                   (channel_r),
    .limited_scan_last_channel_r (limited_scan_last_channel_r),
    .program_lock_r              (program_lock_r),
    .frame_done_r                (frame_done_r),
    .continue_seen_r             (continue_seen_r),
    .alarm_high_r                (alarm_high_r)
);

// *** tb/serial_host_model.sv ***
// Host side of the serial link: sends one 16-bit frame per chip select.
// Assumes callers enter send one small delay after a clk edge.
`timescale 1ns/1ns
module serial_host_model (
    // Serial pins towards the device
    output reg  cs_n,
    output reg  sclk,
    output reg  sdi,
    // Serial data back from the device
    input  wire sdo
);
    integer    b;
    reg [15:0] rx_word;

    // Idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b1;
        rx_word = 16'h0000;
    end

    task send(input [15:0] w);
        begin
            cs_n = 1'b0;
            for (b = 15; b >= 0; b = b - 1) begin
                sdi = w[b];
                // Sample device output just before the rising edge
                #200 rx_word = {rx_word[14:0], sdo};
                sclk = 1'b1;
                #200 sclk = 1'b0;
            end
            #200 cs_n = 1'b1;
            sdi = ~sdi; // Released line shows no stale bit
            #400;
        end
    endtask
endmodule

// *** tb/adc_serial_program_frame_decoder_test.sv ***
// Testbench for the serial program frame decoder.
// Assumes the host model and bound checker; sclk period 400 ns, clk 50 ns.
`timescale 1ns/1ns
`include "frame_decoder_consts.vh"
module adc_serial_program_frame_decoder_test;
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg  [1:0] mode = `MODE_AUTO_LIMITED;
    reg  [3:0] manual_channel = 4'h5;
    reg        conv_valid = 1'b0;
    reg  [3:0] conv_channel = 4'h0;
    reg  [9:0] conv_result = 10'h000;
    wire       cs_n, sclk, sdi, sdo_r, sdo_oe_r, lock, done, cont;
    wire [3:0] chan, last;
    wire [7:0] hi, lo;
    integer    err_count = 0, check_count = 0, dones = 0, conts = 0, sent = 0, i;

    always #25 clk = ~clk;
    // Frame pulses counted for the totals
    always @(posedge clk) begin
        dones <= dones + (done === 1'b1);
        conts <= conts + (cont === 1'b1);
    end

    serial_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_r));
    adc_serial_program_frame_decoder #(.NUM_CH(8)) DUT (
        .clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
        .sdo_r(sdo_r), .sdo_oe_r(sdo_oe_r), .mode(mode), .manual_channel(manual_channel),
        .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_result(conv_result),
        .channel_r(chan), .limited_scan_last_channel_r(last), .program_lock_r(lock),
        .frame_done_r(done), .continue_seen_r(cont), .alarm_high_r(hi), .alarm_low_r(lo));

    task summarize;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    task check(input [8*8-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0s exp %h got %h", name, exp, got);
            end
        end
    endtask

    task frame(input [15:0] w);
        begin
            @(posedge clk);
            #1 host.send(w);
            sent = sent + 1;
        end
    endtask

    // One result pulse, then alarm pair {high, low} of that channel
    task conv_chk(input [3:0] ch, input [9:0] res, input [1:0] exp);
        begin
            @(posedge clk);
            #1 conv_valid = 1'b1;
            conv_channel = ch;
            conv_result = res;
            @(posedge clk);
            #1 conv_valid = 1'b0;
            @(posedge clk);
            #1 check("alarm", {14'h0, exp}, {14'h0, hi[ch[2:0]], lo[ch[2:0]]});
        end
    endtask

    // Hang guard, far beyond the expected few thousand cycles
    initial begin
        #2000000;
        err_count = err_count + 1;
        summarize;
    end

    initial begin
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        #1 check("last", 16'h7, {12'h0, last});
        check("chan", 16'h0, {12'h0, chan});
        // Depth 2 with noise in the ignored bits
        frame(16'h9cbf);
        check("last", 16'h2, {12'h0, last});
        for (i = 0; i < 12 && chan !== 4'h0; i = i + 1)
            frame(16'h0fff);
        for (i = 1; i < 5; i = i + 1) begin
            frame(16'h0fff);
            check("chan", i % 3, {12'h0, chan});
        end
        check("last", 16'h2, {12'h0, last});
        $display("test scan done");
        mode = `MODE_MANUAL;
        frame(16'h0000);
        check("chan", 16'h5, {12'h0, chan});
        mode = `MODE_AUTO_FULL;
        frame(16'h0000);
        check("chan", 16'h6, {12'h0, chan});
        $display("test continue done");
        // Group 1: ch5 high 0x100, ch5 low 0x050, ch6 low 0x3ff with exit
        frame(16'hd3ff);
        check("lock", 16'h1, {15'h0, lock});
        frame(16'h6100);
        check("sdo", 16'h7000, host.rx_word);
        frame(16'h4050);
        check("lock", 16'h1, {15'h0, lock});
        frame(16'h9fff);
        check("lock", 16'h0, {15'h0, lock});
        check("last", 16'h2, {12'h0, last});
        conv_chk(4'h5, 10'h101, 2'b10);
        conv_chk(4'h5, 10'h04f, 2'b01);
        conv_chk(4'h5, 10'h100, 2'b00);
        conv_chk(4'h6, 10'h3fe, 2'b01);
        conv_chk(4'h1, 10'h3ff, 2'b00);
        conv_chk(4'h1, 10'h000, 2'b00);
        conv_chk(4'h7, 10'h2a5, 2'b00);
        $display("test alarm done");
        // Word out carries channel at frame start and latest result
        frame(16'h0000);
        check("sdo", 16'h2a94, host.rx_word);
        check("chan", 16'h3, {12'h0, chan});
        check("oe", 16'h0, {15'h0, sdo_oe_r});
        $display("test serial out done");
        check("frames", sent, dones);
        check("conts", sent - 5, conts);
        summarize;
    end
endmodule
